// *** logic/drgc_pkg.sv ***
// Purpose: Shared constants for the decimation rate and gain control link
// Assumes: One 50 MHz clock; master clock is a divided enable pulse
// Notes:   Both ends refer to these names through drgc_pkg::
`default_nettype none
package drgc_pkg;
    localparam int          NUM_CH          = 6;
    localparam int          GAIN_W          = 3;
    localparam int          GAIN_CFG_W      = NUM_CH * 4;
    localparam int          GAIN_FLD_STRIDE = 4;
    localparam logic [23:0] GAIN_CFG_RST    = 24'h000000;
    // Clock register layout
    localparam int          OSR_LSB         = 2;
    localparam int          PWR_LSB         = 0;
    localparam logic [7:0]  CLK_REG_RST     = 8'h0e;
    localparam logic [1:0]  PWR_VLP         = 2'h0;
    localparam logic [1:0]  PWR_LP          = 2'h1;
    localparam logic [1:0]  PWR_HR          = 2'h2;
    localparam int          MOD_DIV         = 2;
    localparam int          OSR_MIN_LOG2    = 7;
    localparam int          ACC_W           = 16;
    // Master clock dividers from 50 MHz (nearest integer to nominal)
    localparam int          REF_CLK_KHZ     = 50000;
    localparam int          MCLK_HR_KHZ     = 8192;
    localparam int          MCLK_LP_KHZ     = 4096;
    localparam int          MCLK_VLP_KHZ    = 2048;
    localparam logic [7:0]  DIV_HR  = 8'((REF_CLK_KHZ + MCLK_HR_KHZ / 2) / MCLK_HR_KHZ);
    localparam logic [7:0]  DIV_LP  = 8'((REF_CLK_KHZ + MCLK_LP_KHZ / 2) / MCLK_LP_KHZ);
    localparam logic [7:0]  DIV_VLP = 8'((REF_CLK_KHZ + MCLK_VLP_KHZ / 2) / MCLK_VLP_KHZ);
    // Reference settling, in microseconds and cycles
    localparam int          REF_SETTLE_US   = 10;
    localparam int          REF_SETTLE_CYC  = REF_SETTLE_US * REF_CLK_KHZ / 1000;
    // Register addresses on the Wishbone side (byte offsets)
    localparam logic [3:0]  ADR_GAIN        = 4'h0;
    localparam logic [3:0]  ADR_CLOCK       = 4'h4;
    localparam logic [3:0]  ADR_STATUS      = 4'h8;
    localparam logic [3:0]  ADR_DATA        = 4'hc;
endpackage
`default_nettype wire

// *** logic/drgc_if.sv ***
// Purpose: Link between host controller and converter filter
// Assumes: Single clock domain
// Notes:   Config flows to device, data words flow back
`default_nettype none
interface drgc_if;
    logic                          mclk_en;
    logic                          xtal_off;
    logic [drgc_pkg::GAIN_CFG_W-1:0] gain_config_reg;
    logic [7:0]                    clock_reg;
    logic                          mod_bit;
    logic [drgc_pkg::ACC_W-1:0]    data_word;
    logic                          data_valid;
    logic                          ref_ready;
    modport host   (output mclk_en, xtal_off, gain_config_reg, clock_reg, mod_bit,
                    input data_word, data_valid, ref_ready);
    modport device (input mclk_en, xtal_off, gain_config_reg, clock_reg, mod_bit,
                    output data_word, data_valid, ref_ready);
endinterface
`default_nettype wire

// *** logic/drgc_device.sv ***
// Purpose: Rate, gain and decimation end of the converter
// Assumes: Master clock arrives as enable pulse on the link
// Notes:   Sinc1 average; word is ones count scaled by gain shift
`default_nettype none
module drgc_device #(
    parameter int REF_SETTLE = drgc_pkg::REF_SETTLE_CYC
) (
    drgc_if.device                     lnk,
    // Clock and reset
    input  wire logic                  REF_CLK,
    input  wire logic                  RST_N,
    // User side
    input  wire logic [2:0]            CH_SEL,
    output logic [2:0]                 GAIN_SHIFT,
    output logic [1:0]                 POWER_MODE,
    output logic                       MOD_TICK
);
    logic [15:0]                 settle_ff;
    logic                        ready_ff;
    logic                        half_ff;
    logic                        mod_en;
    logic [14:0]                 cnt_ff;
    logic [drgc_pkg::ACC_W-1:0]  acc_ff;
    logic [14:0]                 osr_last;
    logic [2:0]                  osr_sel;
    logic [2:0]                  g_sel;
    logic [4:0]                  ch_idx;

    assign osr_sel  = lnk.clock_reg[drgc_pkg::OSR_LSB +: 3];
    assign osr_last = 15'((32'd1 << (drgc_pkg::OSR_MIN_LOG2 + 32'(osr_sel))) - 32'd1);
    assign ch_idx   = 5'(CH_SEL) * 5'(drgc_pkg::GAIN_FLD_STRIDE);
    // Channels past the last field read gain code zero, never undefined bits
    assign g_sel    = (CH_SEL < 3'(drgc_pkg::NUM_CH)) ?
                      lnk.gain_config_reg[ch_idx +: drgc_pkg::GAIN_W] : 3'h0;
    assign mod_en   = lnk.mclk_en & half_ff;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            settle_ff <= 16'h0000;
            ready_ff  <= 1'b0;
        end else if (!ready_ff) begin
            settle_ff <= settle_ff + 16'h0001;
            ready_ff  <= (settle_ff >= 16'(REF_SETTLE - 1));
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            half_ff <= 1'b0;
        end else if (lnk.mclk_en) begin
            half_ff <= ~half_ff;
        end
    end

    // Decimator restarts while the reference is unsettled
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_ff          <= 15'h0000;
            acc_ff          <= '0;
            lnk.data_word   <= '0;
            lnk.data_valid  <= 1'b0;
        end else begin
            lnk.data_valid <= 1'b0;
            if (!ready_ff) begin
                cnt_ff <= 15'h0000;
                acc_ff <= '0;
            end else if (mod_en) begin
                if (cnt_ff >= osr_last) begin
                    cnt_ff         <= 15'h0000;
                    acc_ff         <= '0;
                    lnk.data_word  <= (acc_ff + 16'(lnk.mod_bit)) << g_sel;
                    lnk.data_valid <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 15'h0001;
                    acc_ff <= acc_ff + 16'(lnk.mod_bit);
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lnk.ref_ready <= 1'b0;
            GAIN_SHIFT    <= 3'h0;
            POWER_MODE    <= drgc_pkg::PWR_HR;
            MOD_TICK      <= 1'b0;
        end else begin
            lnk.ref_ready <= ready_ff;
            GAIN_SHIFT    <= g_sel;
            POWER_MODE    <= lnk.clock_reg[drgc_pkg::PWR_LSB +: 2];
            MOD_TICK      <= mod_en;
        end
    end
endmodule
`default_nettype wire

// *** logic/drgc_host.sv ***
// Purpose: Host end: Wishbone registers, master clock, bit-stream source
// Assumes: Classic Wishbone, one cycle answer
// Notes:   Master clock divider follows the selected power mode
`default_nettype none
module drgc_host (
    drgc_if.host                       lnk,
    // Clock and reset
    input  wire logic                  REF_CLK,
    input  wire logic                  RST_N,
    // Wishbone slave
    input  wire logic                  WB_CYC_I,
    input  wire logic                  WB_STB_I,
    input  wire logic                  WB_WE_I,
    input  wire logic [3:0]            WB_ADR_I,
    input  wire logic [31:0]           WB_DAT_I,
    input  wire logic [3:0]            WB_SEL_I,
    output logic [31:0]                WB_DAT_O,
    output logic                       WB_ACK_O,
    // Modulator stream from analog side
    input  wire logic                  MOD_BIT_IN
);
    logic [7:0]  div_ff;
    logic [7:0]  div_max;
    logic        m1_ff;
    logic        m2_ff;
    logic [15:0] word_ff;
    logic        new_ff;
    logic        req;

    assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

    // Master clock rate tracks the power mode so the host keeps to its range
    always_comb begin
        case (lnk.clock_reg[drgc_pkg::PWR_LSB +: 2])
            drgc_pkg::PWR_HR:  div_max = drgc_pkg::DIV_HR;
            drgc_pkg::PWR_LP:  div_max = drgc_pkg::DIV_LP;
            default:           div_max = drgc_pkg::DIV_VLP;
        endcase
    end

    // Stream sampled on the same clock that paces the device
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_ff      <= 8'h00;
            lnk.mclk_en <= 1'b0;
            m1_ff       <= 1'b0;
            m2_ff       <= 1'b0;
            lnk.mod_bit <= 1'b0;
        end else begin
            m1_ff       <= MOD_BIT_IN;
            m2_ff       <= m1_ff;
            lnk.mod_bit <= m2_ff;
            if (div_ff >= div_max - 8'h01) begin
                div_ff      <= 8'h00;
                lnk.mclk_en <= 1'b1;
            end else begin
                div_ff      <= div_ff + 8'h01;
                lnk.mclk_en <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lnk.gain_config_reg <= drgc_pkg::GAIN_CFG_RST;
            lnk.clock_reg       <= drgc_pkg::CLK_REG_RST;
            lnk.xtal_off        <= 1'b1;
            WB_ACK_O            <= 1'b0;
            WB_DAT_O            <= 32'h00000000;
        end else begin
            WB_ACK_O <= req;
            if (req && WB_WE_I && WB_SEL_I[0]) begin
                case (WB_ADR_I)
                    drgc_pkg::ADR_GAIN:  lnk.gain_config_reg <= WB_DAT_I[23:0];
                    drgc_pkg::ADR_CLOCK: lnk.clock_reg       <= WB_DAT_I[7:0];
                    default: ;
                endcase
            end
            if (req) begin
                case (WB_ADR_I)
                    drgc_pkg::ADR_GAIN:   WB_DAT_O <= {8'h00, lnk.gain_config_reg};
                    drgc_pkg::ADR_CLOCK:  WB_DAT_O <= {24'h000000, lnk.clock_reg};
                    drgc_pkg::ADR_STATUS: WB_DAT_O <= {30'h0, new_ff, lnk.ref_ready};
                    drgc_pkg::ADR_DATA:   WB_DAT_O <= {16'h0000, word_ff};
                    default:              WB_DAT_O <= 32'h00000000;
                endcase
            end
        end
    end

    // New-word flag: set wins over the clear by a data read
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            word_ff <= 16'h0000;
            new_ff  <= 1'b0;
        end else begin
            if (lnk.data_valid) begin
                word_ff <= lnk.data_word;
                new_ff  <= 1'b1;
            end else if (req && !WB_WE_I && WB_ADR_I == drgc_pkg::ADR_DATA) begin
                new_ff <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/drgc_asserts.sv ***
// Purpose: Link checker for both ends
// Assumes: One clock, async low reset
// Notes:   First window after a config change is skipped
`default_nettype none
module drgc_asserts #(
    parameter int REF_SETTLE = drgc_pkg::REF_SETTLE_CYC
) (
    input wire logic       REF_CLK,
    input wire logic       RST_N,
    input wire logic       mclk_en,
    input wire logic [7:0] clock_reg,
    input wire logic       data_valid,
    input wire logic       ref_ready
);
    logic [7:0]  cfg_ff, gap_ff, div;
    logic [15:0] tick_ff, up_ff;
    logic [1:0]  nm_ff, nv_ff;
    logic        chg;
    assign chg = clock_reg != cfg_ff;
    assign div = clock_reg[drgc_pkg::PWR_LSB +: 2] == drgc_pkg::PWR_HR ? drgc_pkg::DIV_HR :
                 clock_reg[drgc_pkg::PWR_LSB +: 2] == drgc_pkg::PWR_LP ? drgc_pkg::DIV_LP :
                 drgc_pkg::DIV_VLP;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_ff  <= drgc_pkg::CLK_REG_RST;
            gap_ff  <= 8'h00;
            tick_ff <= 16'h0000;
            up_ff   <= 16'h0000;
            nm_ff   <= 2'h0;
            nv_ff   <= 2'h0;
        end else begin
            cfg_ff  <= clock_reg;
            gap_ff  <= mclk_en ? 8'h01 : gap_ff + 8'(gap_ff != 8'hff);
            tick_ff <= data_valid ? 16'(mclk_en) : tick_ff + 16'(mclk_en);
            up_ff   <= up_ff + 16'(up_ff != 16'hffff);
            nm_ff   <= chg ? 2'h0 : nm_ff + 2'(mclk_en && nm_ff != 2'h3);
            nv_ff   <= chg ? 2'h0 : nv_ff + 2'(data_valid && nv_ff != 2'h3);
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_one_shot(s);
        s ##1 !s;
    endsequence
    a_valid_one_cycle: assert property (data_valid |-> s_one_shot(data_valid))
        else $error("valid held too long");
    a_mclk_one_cycle: assert property (mclk_en |-> s_one_shot(mclk_en))
        else $error("master clock pulse too long");
    a_no_early_word: assert property (!ref_ready |-> !data_valid)
        else $error("word before reference ready");
    a_ready_stays: assert property (ref_ready |=> ref_ready)
        else $error("reference ready dropped");
    a_ready_not_early: assert property (up_ff < 16'(REF_SETTLE) |-> !ref_ready)
        else $error("reference ready early");
    a_ready_in_time: assert property (up_ff == 16'(REF_SETTLE + 3) |-> ref_ready)
        else $error("reference ready late");
    a_mclk_period: assert property (mclk_en && !chg && nm_ff != 2'h0 |-> gap_ff == div)
        else $error("master clock period off");
    a_word_rate: assert property (data_valid && !chg && nv_ff != 2'h0
        |-> tick_ff == 16'h0100 << clock_reg[drgc_pkg::OSR_LSB +: 3])
        else $error("word rate off");
endmodule
`default_nettype wire

// *** bench/drgc_test.sv ***
// Purpose: Self-checking bench for both link ends
// Assumes: 50 MHz clock, short reference settle
// Notes:   Ratios above 1024 only read back, to keep the run short
`default_nettype none
module drgc_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RS = 4;
    logic        ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, mbit = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'hf;
    logic [31:0] wdat = 32'h0, dout, rd;
    logic [2:0]  ch = 3'h0, gshift;
    logic [1:0]  pmode;
    logic        ack, tick;
    int          miscompares = 0, check_count = 0;
    drgc_if lnk ();
    always #10 ref_clk = ~ref_clk;
    drgc_host drgc_host_inst (.lnk(lnk.host), .REF_CLK(ref_clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
        .WB_DAT_O(dout), .WB_ACK_O(ack), .MOD_BIT_IN(mbit));
    drgc_device #(.REF_SETTLE(RS)) drgc_device_inst (.lnk(lnk.device), .REF_CLK(ref_clk),
        .RST_N(rst_n), .CH_SEL(ch), .GAIN_SHIFT(gshift), .POWER_MODE(pmode), .MOD_TICK(tick));
    drgc_asserts #(.REF_SETTLE(RS)) drgc_asserts_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
        .mclk_en(lnk.mclk_en), .clock_reg(lnk.clock_reg), .data_valid(lnk.data_valid),
        .ref_ready(lnk.ref_ready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            tally_and_finish();
        end
        rd = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Counts cycles and modulator ticks up to the next word
    task automatic wv(output int n, output int t);
        n = 0;
        t = 0;
        do begin
            @(negedge ref_clk);
            n++;
            t += tick;
        end while (lnk.data_valid !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    function automatic int dv(int m);
        return m == 2 ? drgc_pkg::DIV_HR : m == 1 ? drgc_pkg::DIV_LP : drgc_pkg::DIV_VLP;
    endfunction
    initial begin
        int n, t, b, o, m, c, e, gc;
        void'($urandom(2));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        wb(1'b0, drgc_pkg::ADR_CLOCK, 32'h0);
        chk(rd, 32'(drgc_pkg::CLK_REG_RST));
        chk(32'(pmode), 32'(drgc_pkg::PWR_HR));
        wb(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        repeat (RS + 4) @(posedge ref_clk);
        wb(1'b0, drgc_pkg::ADR_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk(32'(lnk.xtal_off), 32'h1);
        $display("reset test done");
        // Two fixed sets reach all eight codes, the third is random
        for (int k = 0; k < 3; k++) begin
            gc = k == 0 ? 32'h543210 : k == 1 ? 32'h107654 : $urandom() & 32'h777777;
            wb(1'b1, drgc_pkg::ADR_GAIN, gc);
            wb(1'b0, drgc_pkg::ADR_GAIN, 32'h0);
            chk(rd, gc);
            for (int i = 0; i < 6; i++) begin
                ch <= 3'(i);
                repeat (3) @(posedge ref_clk);
                chk(32'(gshift), (gc >> 4 * i) & 7);
            end
        end
        $display("gain test done");
        for (int i = 0; i < 6; i++) begin
            m = i < 4 ? 2 : 5 - i;
            o = i < 4 ? i : 0;
            b = i < 2 ? i : $urandom_range(1);
            c = $urandom_range(5);
            ch <= 3'(c);
            mbit <= b[0];
            wb(1'b1, drgc_pkg::ADR_CLOCK, 32'(4 * o + m));
            repeat (3) @(posedge ref_clk);
            chk(32'(pmode), 32'(m));
            wv(n, t);
            wv(n, t);
            e = (b * (128 << o) << ((gc >> 4 * c) & 7)) & 32'hffff;
            chk(32'(lnk.data_word), 32'(e));
            chk(32'(n), 32'((256 << o) * dv(m)));
            chk(32'(t), 32'(128 << o));
            wb(1'b0, drgc_pkg::ADR_STATUS, 32'h0);
            chk(rd, 32'h3);
            wb(1'b0, drgc_pkg::ADR_DATA, 32'h0);
            chk(rd, 32'(e));
            wb(1'b0, drgc_pkg::ADR_STATUS, 32'h0);
            chk(rd, 32'h1);
            $display("conversion %0d done", i);
        end
        // Large ratios cost too many cycles to convert, so only the field is exercised
        for (int k = 4; k < 8; k++) begin
            wb(1'b1, drgc_pkg::ADR_CLOCK, 32'(4 * k + 2));
            wb(1'b0, drgc_pkg::ADR_CLOCK, 32'h0);
            chk(rd, 32'(4 * k + 2));
        end
        $display("ratio field test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
